// [shared/swwdt_pkg.sv]
// package for the software watchdog timer: register frame, field layout,
// reset values and timing counts.
// assumes a 16-bit data bus with 8-bit registers in the low byte.
package swwdt_pkg;
  // register frame in data space
  localparam logic [15:0] SWWDT_FRAME_BASE = 16'h7020;
  localparam logic [15:0] SWWDT_CNT_ADDR = 16'h7023; // counter, read only
  localparam logic [15:0] SWWDT_KEY_ADDR = 16'h7025; // service_key_register
  localparam logic [15:0] SWWDT_CTL_ADDR = 16'h7029; // watchdog_control
  // control field positions
  localparam int SWWDT_CTL_FLAG_BIT = 7;   // reset-cause flag
  localparam int SWWDT_CTL_DIS_BIT = 6;    // disable request
  localparam int SWWDT_CTL_CHK_HI = 5;     // check field top
  localparam int SWWDT_CTL_CHK_LO = 3;     // check field bottom
  localparam int SWWDT_CTL_PS_HI = 2;      // prescale select msb
  // values
  localparam logic [2:0] SWWDT_CHK_PATTERN = 3'h5;  // binary 101
  localparam logic [7:0] SWWDT_CTL_RESET = 8'h00;   // fastest rate
  localparam logic [7:0] SWWDT_KEY_SECOND = 8'haa;  // arbitrary service key
  localparam logic [7:0] SWWDT_KEY_FIRST = 8'h55;   // arbitrary arming key
  // base clock: system clock divided by 512
  localparam int SWWDT_BASE_DIV = 512;
  localparam int SWWDT_BASE_W = 9;
  localparam int SWWDT_PRE_W = 6;         // up to divide by 64
  // arbitrary counter width; 16 steps keeps an unserviced overflow near 8k clocks at /1
  localparam int SWWDT_CNT_W = 4;
  localparam logic [SWWDT_CNT_W-1:0] SWWDT_CNT_MAX = 4'hf;
endpackage : swwdt_pkg

// [rtl/swwdt_prescale.sv]
// prescaler for the software watchdog timer: system clock / 512, then / 2^(n-1) for select n >= 2, / 1 for n < 2.
// assumes a single synchronous clock and active-high synchronous reset.
`timescale 1ns/1ps
module swwdt_prescale
  import swwdt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // control
  input wire logic [2:0] sel_in,
  // enable pulse out
  output logic tick_out
);
  typedef struct packed {
    logic [SWWDT_BASE_W-1:0] base; // divide by 512 counter
    logic [SWWDT_PRE_W-1:0] pre;   // post divider
    logic tick;                    // one-cycle counting enable
  } swwdt_pre_s;

  swwdt_pre_s st_r;
  swwdt_pre_s st_nxt;
  logic base_wrap;
  logic [SWWDT_PRE_W-1:0] pre_mask;

  // mask of post-divider bits that must be all ones for a tick
  always_comb begin
    case (sel_in)
      3'h2: pre_mask = 6'h01;
      3'h3: pre_mask = 6'h03;
      3'h4: pre_mask = 6'h07;
      3'h5: pre_mask = 6'h0f;
      3'h6: pre_mask = 6'h1f;
      3'h7: pre_mask = 6'h3f;
      default: pre_mask = 6'h00; // 00x: divide by 1
    endcase
  end

  // next state: base counter wraps every 512 clocks
  always_comb begin
    st_nxt = st_r;
    base_wrap = (st_r.base == SWWDT_BASE_W'(SWWDT_BASE_DIV - 1)); // RL2
    st_nxt.tick = 1'b0;
    st_nxt.base = st_r.base + 9'h001;
    if (base_wrap) begin
      st_nxt.pre = st_r.pre + 6'h01;
      st_nxt.tick = ((st_r.pre & pre_mask) == pre_mask); // RL8
    end
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule : swwdt_prescale

// [rtl/swwdt_top.sv]
// software watchdog timer: counter, service key, control with check bits.
// assumes the cpu data bus is synchronous to ref_clk_in, with one-cycle
// read and write strobes; the reset output goes to the system reset logic.
`timescale 1ns/1ps
// Overview of operation
// RL1: missed service before overflow resets the system
// RL2: reset selects fastest rate, base clock /512
// RL3: counter runs from reset release, no setup
// RL4: right key clears counter, wrong key resets
// RL5: control check field not 101 resets
// RL6: eight-bit registers, upper byte reads zero
// RL7: disable only while permit bit is one
// RL8: prescale select divides base by 1 to 64
// RL9: three registers in frame at 7020h
// RL10: key and counter width are parameters
// RL11: software must service early after reset
module swwdt_top
  import swwdt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // data bus
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // system level permit, from system_control_status_two bit 5
  input wire logic disable_permit_pin_in,
  // reset request to the system
  output logic sys_reset_out
);
  typedef enum logic [2:0] {
    SWWDT_IDLE = 3'b001,   // no key seen
    SWWDT_ARMED = 3'b010,  // first key seen
    SWWDT_FIRE = 3'b100    // reset pulse issued; state held until a first key or rst_in
  } swwdt_state_e;

  typedef struct packed {
    swwdt_state_e state;             // key sequencer
    logic [SWWDT_CNT_W-1:0] cnt;     // watchdog counter
    logic [7:0] ctl;                 // watchdog_control image
    logic [15:0] rdata;              // read data
    logic rst;                       // reset request
  } swwdt_top_s;

  swwdt_top_s st_r;
  swwdt_top_s st_nxt;
  logic tick;
  logic wr_cnt;
  logic wr_key;
  logic wr_ctl;
  logic disabled;
  logic bad;

  // base clock and prescaler
  swwdt_prescale u_pre (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .sel_in(st_r.ctl[SWWDT_CTL_PS_HI:0]),
    .tick_out(tick)
  );

  // address decode
  always_comb begin
    wr_cnt = 1'b0;
    wr_key = 1'b0;
    wr_ctl = 1'b0;
    if (wr_in && addr_in == SWWDT_KEY_ADDR) begin // RL9
      wr_key = 1'b1;
    end else if (wr_in && addr_in == SWWDT_CTL_ADDR) begin
      wr_ctl = 1'b1;
    end else if (wr_in && addr_in == SWWDT_CNT_ADDR) begin
      wr_cnt = 1'b1; // counter is read only, write ignored
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    bad = 1'b0;
    // disable takes effect only while permit is set
    disabled = st_r.ctl[SWWDT_CTL_DIS_BIT] && disable_permit_pin_in; // RL7
    // counter free runs from reset release
    if (!disabled && tick) begin // RL3
      st_nxt.cnt = st_r.cnt + SWWDT_CNT_W'(1);
      if (st_r.cnt == SWWDT_CNT_MAX) begin
        bad = 1'b1; // RL1 RL10
      end
    end
    // key register: first key arms, second key clears
    if (wr_key) begin
      if (wdata_in[7:0] == SWWDT_KEY_FIRST) begin // RL6
        st_nxt.state = SWWDT_ARMED;
      end else if (wdata_in[7:0] == SWWDT_KEY_SECOND && st_r.state == SWWDT_ARMED) begin
        st_nxt.state = SWWDT_IDLE;
        st_nxt.cnt = '0; // RL4
      end else begin
        bad = 1'b1; // RL4
      end
    end
    // control register with check field
    if (wr_ctl) begin
      if (wdata_in[SWWDT_CTL_CHK_HI:SWWDT_CTL_CHK_LO] != SWWDT_CHK_PATTERN) begin
        bad = 1'b1; // RL5
      end else begin
        // flag bit clears on write of one
        st_nxt.ctl[6:0] = wdata_in[6:0]; // RL6
        if (wdata_in[SWWDT_CTL_FLAG_BIT]) begin
          st_nxt.ctl[SWWDT_CTL_FLAG_BIT] = 1'b0;
        end
      end
    end
    // reset request is one clock wide, then held by system reset
    st_nxt.rst = 1'b0;
    if (bad && st_r.state != SWWDT_FIRE) begin
      st_nxt.rst = 1'b1;
      st_nxt.state = SWWDT_FIRE;
    end
    // read mux, upper byte always zero
    st_nxt.rdata = 16'h0000;
    if (rd_in && addr_in == SWWDT_CNT_ADDR) begin // RL6
      st_nxt.rdata = 16'(st_r.cnt); // counter zero extended
    end else if (rd_in && addr_in == SWWDT_CTL_ADDR) begin
      st_nxt.rdata = {8'h00, st_r.ctl};
    end
  end

  // state register; fastest rate after reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r.state <= SWWDT_IDLE;
      st_r.cnt <= '0;
      st_r.ctl <= SWWDT_CTL_RESET; // RL2
      st_r.rdata <= 16'h0000;
      st_r.rst <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign sys_reset_out = st_r.rst;

  // wrong key raises reset next cycle
  property p_bad_key;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_key && wdata_in[7:0] != SWWDT_KEY_FIRST && wdata_in[7:0] != SWWDT_KEY_SECOND
       && st_r.state == SWWDT_IDLE) |=> sys_reset_out;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key did not reset"); // RL4

  // correct key pair clears the counter
  property p_key_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_key && wdata_in[7:0] == SWWDT_KEY_SECOND && st_r.state == SWWDT_ARMED)
      |=> st_r.cnt == '0;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("service key did not clear"); // RL4

  // bad check field resets
  property p_check;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_ctl && wdata_in[5:3] != 3'h5 && st_r.state != SWWDT_FIRE) |=> sys_reset_out;
  endproperty
  a_check: assert property (p_check) else $error("check field fault missed"); // RL5

  // overflow resets
  property p_overflow;
    @(posedge ref_clk_in) disable iff (rst_in)
      (tick && !disabled && st_r.cnt == SWWDT_CNT_MAX && st_r.state != SWWDT_FIRE)
      |=> sys_reset_out;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow did not reset"); // RL1

  // no counting while permitted and disabled
  property p_disable;
    @(posedge ref_clk_in) disable iff (rst_in)
      (disabled && !wr_key && !wr_ctl) |=> $stable(st_r.cnt);
  endproperty
  a_disable: assert property (p_disable) else $error("counter ran while disabled"); // RL7

  // without permit the counter still advances on a tick
  property p_no_permit;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!disable_permit_pin_in && tick && !wr_key && st_r.cnt != SWWDT_CNT_MAX)
      |=> st_r.cnt == $past(st_r.cnt) + SWWDT_CNT_W'(1);
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("counter stalled without permit"); // RL3

  // upper byte reads zero
  property p_upper;
    @(posedge ref_clk_in) disable iff (rst_in) rdata_out[15:8] == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte not zero"); // RL6

  // reset pulse lasts one cycle
  property p_pulse;
    @(posedge ref_clk_in) disable iff (rst_in) sys_reset_out |=> !sys_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long"); // RL1

  // control register read shows the stored image
  property p_ctl_read;
    @(posedge ref_clk_in) disable iff (rst_in)
      (rd_in && addr_in == SWWDT_CTL_ADDR) |=> rdata_out[7:0] == $past(st_r.ctl);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong"); // RL9

  // counter address ignores writes; only a step may move it
  property p_cnt_ro;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_cnt && !(tick && !disabled)) |=> $stable(st_r.cnt);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("counter took a write"); // RL9
endmodule : swwdt_top

// [dv/swwdt_tb.sv]
// self-checking bench for the software watchdog timer top.
// assumes one-cycle strobes and a registered read answer in the cycle after.
`timescale 1ns/1ps
module testbench;
  import swwdt_pkg::*;
  // design inputs, driven on the falling edge
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic disable_permit_pin_in = 1'b0;
  // design outputs
  logic [15:0] rdata_out;
  logic sys_reset_out;
  // run bookkeeping
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int t;
  logic hit;
  logic [15:0] v;
  logic [7:0] k;
  swwdt_top u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .disable_permit_pin_in(disable_permit_pin_in), .sys_reset_out(sys_reset_out));
  // 10 mhz clock
  always #50 ref_clk_in = ~ref_clk_in;
  // hang guard, sized above the prescale sweep
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      stop_test();
    end
  end
  // verdict and end of run
  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // one compare, reported at once
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // base clocks per step for a prescale code
  function automatic int div_of(input logic [2:0] ps);
    return (ps < 3'h2) ? 1 : (1 << (ps - 1));
  endfunction : div_of
  // one bus cycle, held across one rising edge
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    wr_in = w;
    rd_in = r;
    addr_in = a;
    wdata_in = d;
  endtask : bus
  // drop strobes; the edge just passed has taken the request
  task automatic idle();
    @(negedge ref_clk_in);
    wr_in = 1'b0;
    rd_in = 1'b0;
  endtask : idle
  // write, then look for the reset pulse over two cycles
  task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic exp);
    logic seen;
    bus(1'b1, 1'b0, a, d);
    idle();
    seen = sys_reset_out;
    @(negedge ref_clk_in);
    seen = seen | sys_reset_out;
    chk({15'h0000, seen}, {15'h0000, exp}, "sys_reset_out");
  endtask : wr_chk
  task automatic rd(input logic [15:0] a);
    bus(1'b0, 1'b1, a, 16'h0000);
    idle();
    v = rdata_out;
  endtask : rd
  // back-to-back key pair, no reset expected
  task automatic service();
    bus(1'b1, 1'b0, SWWDT_KEY_ADDR, {8'($urandom), SWWDT_KEY_FIRST});
    wr_chk(SWWDT_KEY_ADDR, {8'h00, SWWDT_KEY_SECOND}, 1'b0);
  endtask : service
  // counter must sit in lo..hi after waiting
  task automatic cnt_in(input int lo, input int hi);
    rd(SWWDT_CNT_ADDR);
    chk({15'h0000, (v >= lo && v <= hi)}, 16'h0001, "counter range");
  endtask : cnt_in
  task automatic do_reset();
    @(negedge ref_clk_in);
    rst_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    rst_in = 1'b0;
  endtask : do_reset
  // main sequence
  initial begin
    void'($urandom(32'hb9b3));
    repeat (5) @(negedge ref_clk_in);
    rst_in = 1'b0;
    rd(SWWDT_CTL_ADDR);
    chk(v, {8'h00, SWWDT_CTL_RESET}, "control reset");
    rd(SWWDT_FRAME_BASE);
    chk(v, 16'h0000, "unmapped read");
    // counter address is read only; a stray write neither lands nor resets
    wr_chk(SWWDT_CNT_ADDR, 16'($urandom), 1'b0);
    // free running from release at the fastest rate, 3.5 steps
    repeat (1780) @(negedge ref_clk_in);
    cnt_in(3, 4);
    // rates with the right check bits; random upper byte must vanish
    // every code from a fresh reset, so the first step lands at a known edge
    for (int ps = 0; ps < 8; ps++) begin
      do_reset();
      wr_chk(SWWDT_CTL_ADDR, {8'($urandom), 2'b00, SWWDT_CHK_PATTERN, 3'(ps)}, 1'b0);
      rd(SWWDT_CTL_ADDR);
      chk(v, {10'h000, SWWDT_CHK_PATTERN, 3'(ps)}, "control readback");
      service();
      cnt_in(0, 0);
      // first step one clock after the divided period; look a few clocks either side
      t = SWWDT_BASE_DIV * div_of(3'(ps));
      repeat (t - 16) @(negedge ref_clk_in);
      cnt_in(0, 0);
      repeat (6) @(negedge ref_clk_in);
      cnt_in(1, 1);
    end
    // disable honoured only with the permit high
    disable_permit_pin_in = 1'b1;
    wr_chk(SWWDT_CTL_ADDR, 16'h0068, 1'b0);
    service();
    repeat (2000) @(negedge ref_clk_in);
    cnt_in(0, 0);
    disable_permit_pin_in = 1'b0;
    repeat (1784) @(negedge ref_clk_in);
    cnt_in(3, 4);
    // never serviced: the counter runs off its top and fires once
    do_reset();
    t = SWWDT_BASE_DIV * (int'(SWWDT_CNT_MAX) + 1);
    repeat (t - 4) @(negedge ref_clk_in);
    chk({15'h0000, sys_reset_out}, 16'h0000, "early overflow");
    hit = 1'b0;
    repeat (8) begin
      @(negedge ref_clk_in);
      hit = hit | sys_reset_out;
    end
    chk({15'h0000, hit}, 16'h0001, "overflow reset");
    // wrong keys, including the second key with no arming first
    for (int i = 0; i < 4; i++) begin
      do_reset();
      k = (i == 0) ? SWWDT_KEY_SECOND : 8'($urandom);
      if (k == SWWDT_KEY_FIRST) begin
        k = k ^ 8'h0f;
      end
      if (i == 3) begin
        k = SWWDT_KEY_SECOND ^ 8'h01;
      end
      wr_chk(SWWDT_KEY_ADDR, {8'h00, k}, 1'b1);
    end
    // every wrong check pattern
    for (int c = 0; c < 8; c++) begin
      if (c != 5) begin
        do_reset();
        wr_chk(SWWDT_CTL_ADDR, {8'($urandom), 2'($urandom), 3'(c), 3'($urandom)}, 1'b1);
      end
    end
    stop_test();
  end
endmodule : testbench
